// ---- fwsr_pkg.sv ----
// Package with constants and carrier types for the flash status poller
package fwsr_pkg;

    // ****************************************
    // Register map of the controller
    // ****************************************
    localparam logic [3:0] FWSR_REG_CTRL = 4'h0;
    localparam logic [3:0] FWSR_REG_CMD = 4'h1;
    localparam logic [3:0] FWSR_REG_STATUS = 4'h2;
    localparam logic [3:0] FWSR_REG_DATA = 4'h3;
    localparam logic [3:0] FWSR_REG_ADDR = 4'h4;
    localparam logic [3:0] FWSR_REG_RDCNT = 4'h5;

    // ****************************************
    // Control field positions
    // ****************************************
    localparam int FWSR_CTRL_START = 0;
    localparam int FWSR_CTRL_ABORT = 1;
    localparam int FWSR_CTRL_USE_SECT = 2;
    localparam int FWSR_CTRL_WINDOW = 3;
    localparam int FWSR_CTRL_WRITE = 4;

    // ****************************************
    // Status field positions
    // ****************************************
    localparam int FWSR_ST_BUSY = 0;
    localparam int FWSR_ST_DONE = 1;
    localparam int FWSR_ST_FAIL = 2;
    localparam int FWSR_ST_WIN_PRE = 3;
    localparam int FWSR_ST_WIN_POST = 4;
    localparam int FWSR_ST_REJECT = 5;
    localparam int FWSR_ST_RDY_PIN = 6;

    // ****************************************
    // Flash data line positions
    // ****************************************
    localparam int FWSR_BIT_SECT_TOGGLE = 2;
    localparam int FWSR_BIT_WINDOW = 3;
    localparam int FWSR_BIT_TIMEOUT = 5;
    localparam int FWSR_BIT_TOGGLE = 6;
    localparam int FWSR_BIT_POLL = 7;

    // ****************************************
    // Bus timing and reset values
    // ****************************************
    localparam int FWSR_CLK_NS = 100;
    localparam int FWSR_STROBE_NS = 200;
    localparam int FWSR_STROBE_CYC = (FWSR_STROBE_NS + FWSR_CLK_NS - 1) / FWSR_CLK_NS;
    localparam logic [7:0] FWSR_RESET_CMD = 8'hf0;
    localparam logic [7:0] FWSR_DATA_RST = 8'h00;
    localparam logic [7:0] FWSR_ADDR_RST = 8'h00;

    // Pin group driven to the flash
    typedef struct packed {
        logic chip_select_n;
        logic output_strobe_n;
        logic write_strobe_n;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic data_oe_n;
    } fwsr_pins_s;

    typedef enum logic [3:0] {
        FWSR_IDLE, FWSR_RD_ON, FWSR_RD_OFF, FWSR_EVAL,
        FWSR_WR_ON, FWSR_WR_OFF, FWSR_DONE
    } fwsr_state_e;

    typedef enum logic [2:0] {
        FWSR_J_FIRST, FWSR_J_SECOND, FWSR_J_RECHECK, FWSR_J_ARRAY,
        FWSR_J_WIN_PRE, FWSR_J_CMD, FWSR_J_WIN_POST
    } fwsr_job_e;

endpackage

// ---- fwsr_sync.sv ----
// Two-stage synchroniser for pins from the flash
`timescale 1ns/1ps
module fwsr_sync #(
    parameter int WIDTH = 9
) (
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_q;

    // First stage feeds only the second
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            meta_q <= '0;
            o_sync <= '0;
        end else begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end
endmodule

// ---- fwsr_ctrl.sv ----
// Host controller that polls flash write status over the parallel pins
//
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
// What this block does
// - Either select or output strobe frames a read; each counts once.
// - Host starts with two full reads and compares toggle bits.
// - After toggle stops, next read gives valid array data.
// - Toggling with timeout flag high: recheck, then fail and reset.
// - Resuming after leaving polling restarts from the first double read.
// - After timeout failure host writes the reset command.
// - Host may skip window flag only if gaps stay under 50 us; here the window control bit chooses it, and no gap timer exists.
// - Host samples window flag before and after each added sector command.
// - Host presents programmed or erase-selected address when polling.
module fwsr_ctrl
    import fwsr_pkg::*;
#(
    parameter int STROBE_CYC = FWSR_STROBE_CYC
) (
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    output logic o_chip_select_n,
    output logic o_output_strobe_n,
    output logic o_write_strobe_n,
    output logic [7:0] o_flash_addr,
    output logic [7:0] o_flash_wdata,
    output logic o_data_oe_n,
    input wire logic [7:0] i_flash_data,
    input wire logic i_ready_busy_out
);
    // ****************************************
    // Synchronised pins
    // ****************************************
    logic [8:0] pin_sync;
    logic [7:0] fdata;
    logic rdy_s;

    fwsr_sync #(.WIDTH(9)) u_sync (
        .i_core_clk(i_core_clk),
        .i_reset_n(i_reset_n),
        .i_async({i_ready_busy_out, i_flash_data}),
        .o_sync(pin_sync)
    );
    assign fdata = pin_sync[7:0];
    assign rdy_s = pin_sync[8];

    // ****************************************
    // State
    // ****************************************
    fwsr_state_e state_q, state_d;
    fwsr_job_e job_q, job_d;
    fwsr_pins_s pins_q, pins_d;
    logic [7:0] cnt_q, cnt_d;
    logic [7:0] addr_q, cmd_q, data_q, rdcnt_q;
    logic use_sect_q;
    logic prev_tog_q, busy_q, done_q, fail_q, win_pre_q, win_post_q, reject_q;
    logic [7:0] samp_q;
    logic [6:0] status_w;

    // Toggle bit chosen for the poll
    function automatic logic tog_of(input logic [7:0] d, input logic sect);
        tog_of = sect ? d[FWSR_BIT_SECT_TOGGLE] : d[FWSR_BIT_TOGGLE];
    endfunction

    // Register decode
    wire wr_ctrl = i_wr && (i_addr == FWSR_REG_CTRL);
    wire start_w = wr_ctrl && i_wdata[FWSR_CTRL_START] && (state_q == FWSR_IDLE);
    wire abort_w = wr_ctrl && i_wdata[FWSR_CTRL_ABORT];
    wire cnt_end = (cnt_q == 8'h00);
    // Decisions use the byte held at the end of the read, lines float after
    wire cur_tog = tog_of(samp_q, use_sect_q);
    wire toggled = cur_tog != prev_tog_q;
    wire tmo_hi = samp_q[FWSR_BIT_TIMEOUT];
    wire win_hi = samp_q[FWSR_BIT_WINDOW];
    assign status_w = {rdy_s, reject_q, win_post_q, win_pre_q, fail_q, done_q, busy_q};

    // Software registers
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            addr_q <= FWSR_ADDR_RST;
            cmd_q <= FWSR_DATA_RST;
            use_sect_q <= 1'b0;
        end else begin
            if (i_wr && i_addr == FWSR_REG_ADDR) addr_q <= i_wdata;
            if (i_wr && i_addr == FWSR_REG_CMD) cmd_q <= i_wdata;
            if (start_w) begin
                use_sect_q <= i_wdata[FWSR_CTRL_USE_SECT];
            end
        end
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            case (i_addr)
                FWSR_REG_STATUS: o_rdata <= {1'b0, status_w};
                FWSR_REG_DATA: o_rdata <= data_q;
                FWSR_REG_ADDR: o_rdata <= addr_q;
                FWSR_REG_CMD: o_rdata <= cmd_q;
                FWSR_REG_RDCNT: o_rdata <= rdcnt_q;
                default: o_rdata <= 8'h00;
            endcase
        end else begin
            o_rdata <= 8'h00;
        end
    end

    // ****************************************
    // Sequencer
    // ****************************************
    // Next state and pin values
    always_comb begin
        state_d = state_q;
        job_d = job_q;
        pins_d = pins_q;
        cnt_d = cnt_end ? 8'h00 : cnt_q - 8'h01;
        case (state_q)
            FWSR_IDLE: begin
                if (start_w) begin
                    // Begin with a fresh double read, or with the window read when the window bit is set
                    job_d = FWSR_J_FIRST;
                    if (i_wdata[FWSR_CTRL_WINDOW]) job_d = FWSR_J_WIN_PRE;
                    state_d = FWSR_RD_ON;
                    cnt_d = STROBE_CYC[7:0];
                    pins_d.addr = addr_q;
                    pins_d.chip_select_n = 1'b0;
                    pins_d.output_strobe_n = 1'b0;
                end
            end
            FWSR_RD_ON: begin
                if (cnt_end) begin
                    // Both strobes released together end one read
                    pins_d.chip_select_n = 1'b1;
                    pins_d.output_strobe_n = 1'b1;
                    state_d = FWSR_RD_OFF;
                    cnt_d = STROBE_CYC[7:0];
                end
            end
            FWSR_RD_OFF: begin
                if (cnt_end) state_d = FWSR_EVAL;
            end
            FWSR_WR_ON: begin
                if (cnt_end) begin
                    pins_d.write_strobe_n = 1'b1;
                    pins_d.chip_select_n = 1'b1;
                    state_d = FWSR_WR_OFF;
                    cnt_d = STROBE_CYC[7:0];
                end
            end
            FWSR_WR_OFF: begin
                if (cnt_end) begin
                    pins_d.data_oe_n = 1'b1;
                    if (job_q == FWSR_J_CMD) begin
                        job_d = FWSR_J_WIN_POST;
                        state_d = FWSR_RD_ON;
                        cnt_d = STROBE_CYC[7:0];
                        pins_d.chip_select_n = 1'b0;
                        pins_d.output_strobe_n = 1'b0;
                    end else begin
                        state_d = FWSR_DONE;
                    end
                end
            end
            FWSR_EVAL: begin
                state_d = FWSR_RD_ON;
                cnt_d = STROBE_CYC[7:0];
                pins_d.chip_select_n = 1'b0;
                pins_d.output_strobe_n = 1'b0;
                case (job_q)
                    FWSR_J_WIN_PRE: begin
                        // Window closed before the command: do not send it
                        if (win_hi) state_d = FWSR_DONE;
                        else job_d = FWSR_J_CMD;
                        if (!win_hi) begin
                            state_d = FWSR_WR_ON;
                            pins_d.output_strobe_n = 1'b1;
                            pins_d.write_strobe_n = 1'b0;
                            pins_d.data_oe_n = 1'b0;
                            pins_d.wdata = cmd_q;
                        end else begin
                            pins_d.chip_select_n = 1'b1;
                            pins_d.output_strobe_n = 1'b1;
                        end
                    end
                    FWSR_J_WIN_POST: begin
                        state_d = FWSR_DONE;
                        pins_d.chip_select_n = 1'b1;
                        pins_d.output_strobe_n = 1'b1;
                    end
                    FWSR_J_FIRST: job_d = FWSR_J_SECOND;
                    FWSR_J_SECOND, FWSR_J_RECHECK: begin
                        if (!toggled) begin
                            job_d = FWSR_J_ARRAY;
                        end else if (job_q == FWSR_J_RECHECK) begin
                            // Still toggling after timeout: send reset
                            state_d = FWSR_WR_ON;
                            pins_d.output_strobe_n = 1'b1;
                            pins_d.write_strobe_n = 1'b0;
                            pins_d.data_oe_n = 1'b0;
                            pins_d.wdata = FWSR_RESET_CMD;
                        end else if (tmo_hi) begin
                            job_d = FWSR_J_RECHECK;
                        end
                    end
                    FWSR_J_ARRAY: begin
                        state_d = FWSR_DONE;
                        pins_d.chip_select_n = 1'b1;
                        pins_d.output_strobe_n = 1'b1;
                    end
                    default: state_d = FWSR_DONE;
                endcase
                if (abort_w) begin
                    state_d = FWSR_DONE;
                    pins_d.chip_select_n = 1'b1;
                    pins_d.output_strobe_n = 1'b1;
                    pins_d.write_strobe_n = 1'b1;
                    pins_d.data_oe_n = 1'b1;
                end
            end
            FWSR_DONE: state_d = FWSR_IDLE;
            default: state_d = FWSR_IDLE;
        endcase
    end

    // Sequencer registers
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_q <= FWSR_IDLE;
            job_q <= FWSR_J_FIRST;
            cnt_q <= 8'h00;
            pins_q <= '{1'b1, 1'b1, 1'b1, 8'h00, 8'h00, 1'b1};
        end else begin
            state_q <= state_d;
            job_q <= job_d;
            cnt_q <= cnt_d;
            pins_q <= pins_d;
        end
    end

    // Sample and status flags
    wire eval_w = (state_q == FWSR_EVAL);
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            samp_q <= 8'h00;
            prev_tog_q <= 1'b0;
            data_q <= FWSR_DATA_RST;
            rdcnt_q <= 8'h00;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            fail_q <= 1'b0;
            win_pre_q <= 1'b0;
            win_post_q <= 1'b0;
            reject_q <= 1'b0;
        end else begin
            if (state_q == FWSR_RD_ON && cnt_end) samp_q <= fdata;
            if (eval_w) begin
                prev_tog_q <= cur_tog;
                rdcnt_q <= rdcnt_q + 8'h01;
            end
            if (eval_w && job_q == FWSR_J_ARRAY) data_q <= samp_q;
            if (eval_w && job_q == FWSR_J_WIN_PRE) win_pre_q <= win_hi;
            if (eval_w && job_q == FWSR_J_WIN_POST) begin
                win_post_q <= win_hi;
                reject_q <= win_hi;
            end
            if (eval_w && job_q == FWSR_J_RECHECK && toggled) fail_q <= 1'b1;
            if (start_w) begin
                busy_q <= 1'b1;
                done_q <= 1'b0;
                fail_q <= 1'b0;
                reject_q <= 1'b0;
                rdcnt_q <= 8'h00;
            end else if (state_q == FWSR_DONE) begin
                busy_q <= 1'b0;
                done_q <= 1'b1;
            end
        end
    end

    // Pins straight from flops
    assign o_chip_select_n = pins_q.chip_select_n;
    assign o_output_strobe_n = pins_q.output_strobe_n;
    assign o_write_strobe_n = pins_q.write_strobe_n;
    assign o_flash_addr = pins_q.addr;
    assign o_flash_wdata = pins_q.wdata;
    assign o_data_oe_n = pins_q.data_oe_n;

    // ****************************************
    // Checks
    // ****************************************
    property p_second_read;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        (eval_w && job_q == FWSR_J_FIRST) |=> (job_q == FWSR_J_SECOND);
    endproperty
    a_second_read: assert property (p_second_read) else $error("second read skipped");

    property p_array_after_stop;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        (eval_w && job_q == FWSR_J_SECOND && !toggled && !abort_w) |=> (job_q == FWSR_J_ARRAY);
    endproperty
    a_array_after_stop: assert property (p_array_after_stop) else $error("no data read");

    property p_fail_reset;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        (eval_w && job_q == FWSR_J_RECHECK && toggled && !abort_w)
            |=> (!o_write_strobe_n && o_flash_wdata == FWSR_RESET_CMD && fail_q);
    endproperty
    a_fail_reset: assert property (p_fail_reset) else $error("reset not written");

    property p_recheck;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        (eval_w && job_q == FWSR_J_SECOND && toggled && tmo_hi && !abort_w)
            |=> (job_q == FWSR_J_RECHECK);
    endproperty
    a_recheck: assert property (p_recheck) else $error("recheck missed");

    property p_restart;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        (start_w && !i_wdata[FWSR_CTRL_WINDOW]) |=> (job_q == FWSR_J_FIRST && !o_chip_select_n);
    endproperty
    a_restart: assert property (p_restart) else $error("poll not restarted");

    sequence s_rd_frame;
        !o_chip_select_n && !o_output_strobe_n;
    endsequence
    property p_read_frame;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        $rose(o_output_strobe_n) |-> o_chip_select_n && $past(o_write_strobe_n);
    endproperty
    a_read_frame: assert property (p_read_frame) else $error("read frame broken");

    property p_addr_held;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        s_rd_frame |-> (o_flash_addr == $past(o_flash_addr) || $past(state_q) == FWSR_IDLE);
    endproperty
    a_addr_held: assert property (p_addr_held) else $error("address moved");

    property p_window_check;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        (eval_w && job_q == FWSR_J_WIN_POST) |=> (reject_q == $past(win_hi));
    endproperty
    a_window_check: assert property (p_window_check) else $error("window check lost");
endmodule

// ---- fwsr_flash_model.sv ----
// Behavioural flash device answering status reads for the poller
`timescale 1ns/1ps
module fwsr_flash_model
    import fwsr_pkg::*;
(
    input wire logic i_chip_select_n,
    input wire logic i_output_strobe_n,
    input wire logic i_write_strobe_n,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_data_oe_n,
    output logic [7:0] o_data,
    output logic o_ready_busy_out
);
    // ****************************************
    // Device state loaded per scenario
    // ****************************************
    int left = 0;
    int writes = 0;
    logic tog = 1'b0;
    logic stog = 1'b0;
    logic susp = 1'b0;
    logic fail = 1'b0;
    logic win = 1'b0;
    logic win_after = 1'b0;
    logic [7:0] arr = 8'h00;
    logic [3:0] sect = 4'h0;
    logic [7:0] last = 8'h00;
    logic [7:0] cmd = 8'h00;
    logic [7:0] pend = 8'h00;
    // Read and write cycles framed by select and strobes
    wire rd_act = !i_chip_select_n && !i_output_strobe_n;
    wire wr_act = !i_chip_select_n && !i_write_strobe_n;
    wire busy = left > 0;
    wire in_sect = i_addr[7:4] == sect;
    // Status byte while busy, array data otherwise
    wire [7:0] stat = {~arr[7], tog, fail, 1'b0, win, in_sect & stog, 2'b00};
    wire [7:0] cur = busy ? stat : arr;
    // Released lines show the inverse of the last value
    assign o_data = rd_act ? cur : ~last;
    assign o_ready_busy_out = !busy || susp;
    // Toggle once per finished read while busy
    always @(negedge rd_act) begin
        last = cur;
        if (busy) begin
            stog = ~stog;
            if (!susp) tog = ~tog;
            left = left - 1;
        end
    end
    // Hold the data of a write while it is active
    always @* begin
        if (wr_act && !i_data_oe_n) begin
            pend = i_wdata;
        end
    end
    // Commit a write at its trailing edge
    always @(negedge wr_act) begin
        writes = writes + 1;
        // Closed window: the command is ignored
        if (!win) begin
            cmd = pend;
            if (pend == FWSR_RESET_CMD) left = 0;
        end
        win = win_after;
    end
    // Load one operation: busy reads, timeout, array byte, sector, window
    task automatic start_op(input int k, input logic f, input logic [7:0] a,
                            input logic [3:0] s, input logic w, input logic wa);
        left = k;
        tog = 1'b0;
        stog = 1'b0;
        susp = 1'b0;
        fail = f;
        arr = a;
        sect = s;
        win = w;
        win_after = wa;
        writes = 0;
        cmd = 8'h00;
    endtask
endmodule

// ---- tb_top.sv ----
// Self-checking bench for the flash status poller
`timescale 1ns/1ps
module tb_top
    import fwsr_pkg::*;
;
    // ****************************************
    // Signals and bookkeeping
    // ****************************************
    typedef struct packed {
        logic [7:0] val;
        logic [7:0] mask;
    } fwsr_note_s;
    logic i_core_clk, i_reset_n, i_wr, i_rd, cs_n, os_n, ws_n, oe_n, rdy, rd_d1, w, wa;
    logic [3:0] i_addr;
    logic [7:0] i_wdata, o_rdata, faddr, fwdata, fdata, bus, v, a;
    logic [31:0] seed = 32'h1fe4;
    int fail_count = 0;
    int checks_done = 0;
    int k;
    fwsr_note_s notes[$];
    fwsr_note_s nt;
    // Host drives the shared data lines while its enable is low
    assign bus = !oe_n ? fwdata : fdata;
    fwsr_ctrl #(.STROBE_CYC(2)) DUT (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .o_chip_select_n(cs_n), .o_output_strobe_n(os_n), .o_write_strobe_n(ws_n),
        .o_flash_addr(faddr), .o_flash_wdata(fwdata), .o_data_oe_n(oe_n),
        .i_flash_data(bus), .i_ready_busy_out(rdy));
    fwsr_flash_model u_flash (.i_chip_select_n(cs_n), .i_output_strobe_n(os_n),
        .i_write_strobe_n(ws_n), .i_addr(faddr), .i_wdata(fwdata), .i_data_oe_n(oe_n),
        .o_data(fdata), .o_ready_busy_out(rdy));
    // Clock of 100 ns period
    initial begin
        i_core_clk = 1'b0;
        forever #50 i_core_clk = ~i_core_clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m);
        checks_done++;
        if ((got & m) !== (exp & m)) begin
            fail_count++;
            $display("BAD %0t got %h expected %h mask %h", $time, got, exp, m);
        end
    endtask
    task automatic wr(input logic [3:0] ad, input logic [7:0] d);
        @(posedge i_core_clk);
        i_addr <= ad;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] ad, input logic [7:0] e, input logic [7:0] m);
        notes.push_back({e, m});
        @(posedge i_core_clk);
        i_addr <= ad;
        i_rd <= 1'b1;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
    endtask
    // Start a poll job and wait until busy clears
    task automatic job(input logic [7:0] fa, input logic [7:0] ctrl, input int kk);
        int n;
        wr(FWSR_REG_ADDR, fa);
        wr(FWSR_REG_CTRL, ctrl);
        repeat (2) @(posedge i_core_clk);
        if (kk > 8) rd(FWSR_REG_STATUS, 8'h01, 8'h41);
        n = 0;
        v = 8'h01;
        while (v[FWSR_ST_BUSY] !== 1'b0 && n < 3000) begin
            rd(FWSR_REG_STATUS, 8'h00, 8'h00);
            #1 v = o_rdata;
            n++;
        end
        if (n >= 3000) begin
            fail_count++;
            $display("BAD %0t busy never cleared", $time);
        end
        rd(FWSR_REG_ADDR, fa, 8'hff);
    endtask
    // Compare each read answer with the oldest note
    always @(posedge i_core_clk) begin
        if (rd_d1 === 1'b1 && notes.size() > 0) begin
            nt = notes.pop_front();
            if (nt.mask != 8'h00) chk(o_rdata, nt.val, nt.mask);
        end
        rd_d1 <= i_rd;
    end
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Watchdog against a hung poll
    initial begin
        repeat (60000) @(posedge i_core_clk);
        fail_count++;
        $display("BAD %0t watchdog expired", $time);
        final_report();
    end
    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        i_reset_n = 1'b0;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = 4'h0;
        i_wdata = 8'h00;
        repeat (2) @(posedge i_core_clk);
        i_reset_n <= 1'b1;
        repeat (4) @(posedge i_core_clk);
        rd(FWSR_REG_STATUS, 8'h40, 8'h7f);
        rd(FWSR_REG_DATA, FWSR_DATA_RST, 8'hff);
        rd(FWSR_REG_ADDR, FWSR_ADDR_RST, 8'hff);
        rd(FWSR_REG_RDCNT, 8'h00, 8'hff);
        rd(4'hf, 8'h00, 8'hff);
        // Already finished: two equal reads then one array read
        u_flash.start_op(0, 1'b0, 8'ha5, 4'h5, 1'b0, 1'b0);
        job(8'h12, 8'h01, 0);
        rd(FWSR_REG_STATUS, 8'h02, 8'h07);
        rd(FWSR_REG_RDCNT, 8'h03, 8'hff);
        rd(FWSR_REG_DATA, 8'ha5, 8'hff);
        // Toggling jobs on the device bit and on the sector bit
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            k = (i == 3) ? 40 : 1 + int'(seed[2:0] % 3'd6);
            a = seed[15:8];
            a[FWSR_BIT_TOGGLE] = ~k[0];
            a[FWSR_BIT_SECT_TOGGLE] = ~k[0];
            u_flash.start_op(k, 1'b0, a, 4'h5, 1'b0, 1'b0);
            job({4'h5, seed[19:16]}, i[0] ? 8'h05 : 8'h01, k);
            rd(FWSR_REG_STATUS, 8'h02, 8'h07);
            rd(FWSR_REG_DATA, a, 8'hff);
        end
        // Sector bit steady outside the selected sector
        u_flash.start_op(20, 1'b0, 8'h00, 4'h5, 1'b0, 1'b0);
        job(8'h73, 8'h05, 20);
        rd(FWSR_REG_RDCNT, 8'h03, 8'hff);
        // Erase suspended: device bit steady, ready pin high
        u_flash.start_op(6, 1'b0, 8'h00, 4'h5, 1'b0, 1'b0);
        u_flash.susp = 1'b1;
        job(8'h5a, 8'h01, 6);
        rd(FWSR_REG_RDCNT, 8'h03, 8'hff);
        rd(FWSR_REG_STATUS, 8'h42, 8'h47);
        // Timeout high but toggling stops at the recheck
        u_flash.start_op(2, 1'b1, 8'h4c, 4'h5, 1'b0, 1'b0);
        job(8'h21, 8'h01, 2);
        rd(FWSR_REG_STATUS, 8'h02, 8'h07);
        rd(FWSR_REG_DATA, 8'h4c, 8'hff);
        // Timeout high and still toggling: failure and reset command
        u_flash.start_op(200, 1'b1, 8'h00, 4'h5, 1'b0, 1'b0);
        job(8'h22, 8'h01, 200);
        rd(FWSR_REG_STATUS, 8'h04, 8'h05);
        chk(u_flash.cmd, FWSR_RESET_CMD, 8'hff);
        chk(u_flash.writes[7:0], 8'h01, 8'hff);
        // Window flag before and after an added command
        for (int i = 0; i < 3; i++) begin
            w = (i == 2);
            wa = (i != 0);
            wr(FWSR_REG_CMD, 8'h30);
            rd(FWSR_REG_CMD, 8'h30, 8'hff);
            u_flash.start_op(100, 1'b0, 8'h00, 4'h5, w, wa);
            job(8'h54, 8'h09, 0);
            rd(FWSR_REG_STATUS, {2'b00, wa, wa, w, 3'b010}, w ? 8'h0b : 8'h3b);
            chk(u_flash.writes[7:0], {7'h00, ~w}, 8'hff);
            chk(u_flash.cmd, 8'h30, w ? 8'h00 : 8'hff);
        end
        repeat (4) @(posedge i_core_clk);
        final_report();
    end
endmodule
